// file: hdl/snf_pkg.sv
// Shared constants and types of the serial NAND SPI front end.
package snf_pkg;
  // Opcodes.
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RST  = 8'hFF;
  localparam logic [7:0] OP_PGRD = 8'h13;
  localparam logic [7:0] OP_PGEX = 8'h10;
  localparam logic [7:0] OP_BERS = 8'hD8;
  localparam logic [7:0] OP_PLD  = 8'h84;
  localparam logic [7:0] OP_PLDR = 8'h02;
  localparam logic [7:0] OP_RC1  = 8'h03;
  localparam logic [7:0] OP_RC1F = 8'h0B;
  localparam logic [7:0] OP_RC2  = 8'h3B;
  localparam logic [7:0] OP_RC4  = 8'h6B;
  localparam logic [7:0] OP_GETF = 8'h0F;
  localparam logic [7:0] OP_SETF = 8'h1F;
  localparam logic [7:0] OP_RDID = 8'h9F;
  // Address bytes after the opcode, seen by the command decoder.
  localparam logic [1:0] ROW_BYTES  = 2'h3;
  localparam logic [1:0] COL_BYTES  = 2'h2;
  localparam logic [1:0] FEAT_BYTES = 2'h1;
  // Bytes before read data on the link, opcode included; then the byte count ceiling and the last bit index.
  localparam logic [2:0] HDR_CACHE = 3'h4;
  localparam logic [2:0] HDR_SHORT = 3'h2;
  localparam logic [2:0] BYTE_SAT  = 3'h4;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  // Page geometry: 2048 main plus 64 spare bytes; 64 pages; 2 x 512 blocks.
  localparam logic [12:0] PAGE_BYTES = 13'h0840;
  localparam int PAGE_W        = 6;
  localparam int BLOCK_W       = 10;
  localparam int PLANE_ROW_BIT = 6;
  localparam int PLANE_COL_BIT = 12;
  // Feature addresses, writable masks, reset values and bit positions.
  localparam logic [7:0] FA_LOCK   = 8'hA0;
  localparam logic [7:0] FA_OTP    = 8'hB0;
  localparam logic [7:0] FA_STAT   = 8'hC0;
  localparam logic [7:0] LOCK_MASK = 8'hB8;
  localparam logic [7:0] OTP_MASK  = 8'hD0;
  localparam logic [7:0] LOCK_RST  = 8'h00;
  localparam logic [7:0] OTP_RST   = 8'h00;
  localparam int LOCK_WD_BIT = 7;
  localparam int ECC_EN_BIT  = 4;
  // Data lanes of a read.
  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;
  // Source of read data on the link.
  typedef enum logic [1:0] {RK_NONE, RK_FEAT, RK_ID, RK_CACHE} snf_rkind_t;
endpackage

// file: hdl/snf_front_end.sv
// Serial NAND SPI front end: link deserialiser, read serialiser and command decoder.
`timescale 1ns/1ps
// Function
// - Sample command, address and write bits on the rising link clock edge.
// - Change output bits only on falling link clock edges.
// - Chip select high deselects, floats outputs; low activates the link.
// - Ignore commands until chip select has been high after reset.
// - Modes 0 and 3 both: rising edge samples, falling edge drives.
// - Pause starts at pause pin fall if clock low, else after falling edge.
// - Pause ends at pause pin rise if clock low, else after falling edge.
// - While paused, outputs float, input and clock are ignored, state kept.
// - Pause stops only the link; core operations carry on.
// - Pause acts only while chip select is low.
// - Dual and quad reads drive bit zero on the serial input pin.
// - Quad reads drive bit three on pause pin, bit two on protect pin.
// - Protect pin low with write-disable set refuses lock bit writes.
// - Column is 12 bits; bytes 2112 to 4095 are out of bounds.
// - Row address bit six, the lowest block bit, selects one of two planes.
// - A block holds 64 pages of 2048 plus 64 bytes.
// - Two planes of 512 blocks, 1024 blocks addressable.
// - Internal ECC is switched by the feature register enable bit.
// - Array works by page through cache, erases by block.
// - Serial output pin is the single-line output, bit one otherwise.
// - Dual 3Bh and quad 6Bh take two address bytes and one dummy.
module snf_front_end #(
  parameter logic [7:0] ID_MAKER = 8'hA5, // Arbitrary value, maker code.
  parameter logic [7:0] ID_PART  = 8'h5A  // Arbitrary value, part code.
) (
  input  wire logic        sys_clk,             // Core clock.
  input  wire logic        rst,                 // Asynchronous reset, high.
  input  wire logic        spiClk,              // Link clock from the host.
  input  wire logic        csN,                 // Chip select, low active.
  input  wire logic        serialInOrOutBit0I,  // Data pin 0 level.
  output wire logic        serialInOrOutBit0O,  // Data pin 0 drive value.
  output wire logic        serialInOrOutBit0Oe, // Data pin 0 drive enable.
  output wire logic        serialOutOrBit1O,    // Data pin 1 drive value.
  output wire logic        serialOutOrBit1Oe,   // Data pin 1 drive enable.
  input  wire logic        protectOrOutBit2I,   // Protect pin level.
  output wire logic        protectOrOutBit2O,   // Protect pin drive value.
  output wire logic        protectOrOutBit2Oe,  // Protect pin drive enable.
  input  wire logic        pauseOrOutBit3I,     // Pause pin level.
  output wire logic        pauseOrOutBit3O,     // Pause pin drive value.
  output wire logic        pauseOrOutBit3Oe,    // Pause pin drive enable.
  output wire logic        cmdValid,            // Command pulse to the core.
  output wire logic [7:0]  cmdOpcode,           // Command opcode.
  output wire logic [9:0]  cmdBlock,            // Block of a row command.
  output wire logic [5:0]  cmdPage,             // Page of a row command.
  output wire logic        cmdPlane,            // Plane of the command.
  output wire logic [11:0] cmdCol,              // Column of a load command.
  output wire logic        wrValid,             // Write data byte pulse.
  output wire logic [7:0]  wrData,              // Write data byte.
  output wire logic [11:0] wrCol,               // Column of the write byte.
  output wire logic        rdReq,               // Cache byte request pulse.
  output wire logic [11:0] rdCol,               // Column requested.
  input  wire logic [7:0]  rdData,              // Cache byte from the core.
  input  wire logic        rdAck,               // Cache byte valid pulse.
  input  wire logic [7:0]  statusIn,            // Core status feature.
  output wire logic [7:0]  lockReg,             // Block lock feature.
  output wire logic [7:0]  otpReg,              // OTP and ECC feature.
  output wire logic        eccEnable,           // Internal ECC on.
  output wire logic        lockRefused          // Refused lock write pulse.
);

  // Link state, frame scope except armQ, which only the reset clears.
  logic                   armQ;
  logic [6:0]             shQ;
  logic [2:0]             bitQ;
  logic [2:0]             byteQ;
  logic [7:0]             opQ;
  logic [7:0]             faQ;
  logic [11:0]            colQ;
  logic                   dataQ;
  snf_pkg::snf_rkind_t    kindQ;
  logic [2:0]             laneQ;
  logic [7:0]             txQ;
  logic [2:0]             leftQ;
  logic [12:0]            txColQ;
  logic                   startedQ;
  logic                   oobQ;
  logic [3:0]             outQ;
  logic [3:0]             oeQ;
  // Crossing registers, cleared only by the reset.
  logic                   rxTglQ;
  logic [7:0]             rxByteQ;
  logic                   rxFirstQ;
  logic                   nxTglQ;
  // Core side.
  logic [2:0]             rxSyncQ;
  logic [2:0]             nxSyncQ;
  logic [1:0]             wpSyncQ;
  logic [7:0]             cOpQ;
  logic [1:0]             cCntQ;
  logic [15:0]            cAddrQ;
  logic                   cmdValidQ;
  logic [7:0]             cmdOpQ;
  logic [9:0]             blockQ;
  logic [5:0]             pageQ;
  logic                   planeQ;
  logic [11:0]            cmdColQ;
  logic                   wrValidQ;
  logic [7:0]             wrDataQ;
  logic [12:0]            wrColQ;
  logic [11:0]            wrByteColQ;
  logic                   rdReqQ;
  logic [11:0]            rdColQ;
  logic [7:0]             holdQ;
  logic [7:0]             statQ;
  logic [7:0]             lockQ;
  logic [7:0]             otpQ;
  logic                   refusedQ;

  // Chip select high holds the frame logic in reset, which also drops any half command.
  // Deselect clears frame
  wire logic linkRst = rst | csN;

  // The first falling edge of chip select after reset arms the link for good.
  // Arm on select fall
  always_ff @(negedge csN or posedge rst) begin
    if (rst) begin
      armQ <= 1'b0;
    end else begin
      armQ <= 1'b1;
    end
  end

  // The pause pin is an output during the quad data phase, so it cannot pause there.
  wire logic quadOut  = dataQ & (laneQ == snf_pkg::LANE4);
  wire logic pauseReq = ~pauseOrOutBit3I & ~quadOut;

  // Input decode; the link stops taking bits once read data starts.
  wire logic       rxTake  = armQ & ~pauseReq & ~dataQ;
  wire logic       rxDone  = rxTake & (bitQ == snf_pkg::BIT_LAST);
  wire logic [7:0] rxWord  = {shQ, serialInOrOutBit0I};
  wire logic [7:0] opNow   = (byteQ == 3'h0) ? rxWord : opQ;
  wire logic       isC1    = (opNow == snf_pkg::OP_RC1) | (opNow == snf_pkg::OP_RC1F);
  wire logic       isC2    = opNow == snf_pkg::OP_RC2;
  wire logic       isC4    = opNow == snf_pkg::OP_RC4;
  wire logic       isCache = isC1 | isC2 | isC4;
  wire logic       isShort = (opNow == snf_pkg::OP_GETF) | (opNow == snf_pkg::OP_RDID);
  wire logic [2:0] hdrLen  = isCache ? snf_pkg::HDR_CACHE
                           : isShort ? snf_pkg::HDR_SHORT : 3'h0;
  wire logic       hdrEnd  = rxDone & (hdrLen != 3'h0) & (byteQ + 3'h1 == hdrLen);

  // Rising edge: deserialise bytes and decode the read header.
  // Rising edge sample
  always_ff @(posedge spiClk or posedge linkRst) begin
    if (linkRst) begin
      shQ   <= 7'h00;
      bitQ  <= 3'h0;
      byteQ <= 3'h0;
      opQ   <= 8'h00;
      faQ   <= 8'h00;
      colQ  <= 12'h000;
      dataQ <= 1'b0;
      kindQ <= snf_pkg::RK_NONE;
      laneQ <= snf_pkg::LANE1;
    end else if (rxTake) begin
      shQ  <= rxWord[6:0];
      bitQ <= bitQ + 3'h1;
      if (rxDone) begin
        byteQ <= (byteQ == snf_pkg::BYTE_SAT) ? byteQ : byteQ + 3'h1;
        opQ   <= opNow;
        faQ   <= (byteQ == 3'h1) ? rxWord : faQ;
        colQ  <= (isCache && byteQ == 3'h1) ? {rxWord[3:0], 8'h00}
               : (isCache && byteQ == 3'h2) ? {colQ[11:8], rxWord} : colQ;
        dataQ <= hdrEnd;
        kindQ <= isCache ? snf_pkg::RK_CACHE
               : (opNow == snf_pkg::OP_GETF) ? snf_pkg::RK_FEAT
               : (opNow == snf_pkg::OP_RDID) ? snf_pkg::RK_ID : snf_pkg::RK_NONE;
        laneQ <= isC4 ? snf_pkg::LANE4 : isC2 ? snf_pkg::LANE2 : snf_pkg::LANE1;
      end
    end
  end

  // Each received byte crosses as a toggle; the byte stays put for a whole byte time.
  always_ff @(posedge spiClk or posedge rst) begin
    if (rst) begin
      rxTglQ   <= 1'b0;
      rxByteQ  <= 8'h00;
      rxFirstQ <= 1'b0;
    end else if (rxDone) begin
      rxTglQ   <= ~rxTglQ;
      rxByteQ  <= rxWord;
      rxFirstQ <= byteQ == 3'h0;
    end
  end

  // Output word selection; the feature and hold words are taken as they stand at each byte load.
  wire logic        txRun    = dataQ & ~pauseReq;
  wire logic        txLoad   = txRun & (leftQ == 3'h0);
  wire logic [12:0] colBase  = startedQ ? txColQ : {1'b0, colQ};
  wire logic [7:0]  featWord = (faQ == snf_pkg::FA_LOCK) ? lockQ
                             : (faQ == snf_pkg::FA_OTP)  ? otpQ
                             : (faQ == snf_pkg::FA_STAT) ? statQ : 8'h00;
  wire logic [7:0]  idWord   = colBase[0] ? ID_PART : ID_MAKER;
  wire logic [7:0]  newWord  = (kindQ == snf_pkg::RK_CACHE) ? holdQ
                             : (kindQ == snf_pkg::RK_FEAT) ? featWord : idWord;
  wire logic [7:0]  curWord  = txLoad ? newWord : txQ;
  wire logic        newOob   = (kindQ == snf_pkg::RK_CACHE) & (colBase >= snf_pkg::PAGE_BYTES);
  wire logic        curOob   = txLoad ? newOob : oobQ;
  wire logic        quad     = laneQ == snf_pkg::LANE4;
  wire logic [3:0]  laneBits = quad ? curWord[7:4] : {2'h0, curWord[7:6]};
  wire logic [3:0]  laneOe   = quad ? 4'hF : (laneQ == snf_pkg::LANE2) ? 4'h3 : 4'h2;

  // Falling edge: drive the lanes; paused or idle cycles float every pin.
  // Falling edge drive
  always_ff @(negedge spiClk or posedge linkRst) begin
    if (linkRst) begin
      txQ      <= 8'h00;
      leftQ    <= 3'h0;
      txColQ   <= 13'h0000;
      startedQ <= 1'b0;
      oobQ     <= 1'b0;
      outQ     <= 4'h0;
      oeQ      <= 4'h0;
    end else if (txRun) begin
      txQ      <= curWord << laneQ;
      // Unsigned wrap: zero minus lanes gives the bits left after a load.
      leftQ    <= (txLoad ? 3'h0 : leftQ) - laneQ;
      txColQ   <= txLoad ? colBase + 13'h0001 : txColQ;
      startedQ <= 1'b1;
      oobQ     <= curOob;
      outQ     <= laneBits;
      oeQ      <= curOob ? 4'h0 : laneOe;
    end else begin
      oeQ      <= 4'h0;
    end
  end

  // Every cache byte taken asks the core for the next one.
  always_ff @(negedge spiClk or posedge rst) begin
    if (rst) begin
      nxTglQ <= 1'b0;
    end else if (txLoad && kindQ == snf_pkg::RK_CACHE) begin
      nxTglQ <= ~nxTglQ;
    end
  end

  // Pin order: bit 0 on the input pin, bit 1 on the output pin, then protect, then pause.
  // Pin drive
  assign serialInOrOutBit0O  = outQ[0];
  assign serialInOrOutBit0Oe = oeQ[0];
  assign serialOutOrBit1O    = outQ[1];
  assign serialOutOrBit1Oe   = oeQ[1];
  assign protectOrOutBit2O   = outQ[2];
  assign protectOrOutBit2Oe  = oeQ[2];
  assign pauseOrOutBit3O     = outQ[3];
  assign pauseOrOutBit3Oe    = oeQ[3];

  // Synchronisers: the first stage feeds only the second.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxSyncQ <= 3'h0;
      nxSyncQ <= 3'h0;
      wpSyncQ <= 2'h0;
    end else begin
      rxSyncQ <= {rxSyncQ[1:0], rxTglQ};
      nxSyncQ <= {nxSyncQ[1:0], nxTglQ};
      wpSyncQ <= {wpSyncQ[0], protectOrOutBit2I};
    end
  end

  // Command decode on the core side; a new opcode byte drops any unfinished command.
  wire logic        rxEvt    = rxSyncQ[2] ^ rxSyncQ[1];
  wire logic        nxEvt    = nxSyncQ[2] ^ nxSyncQ[1];
  wire logic        isRow    = (cOpQ == snf_pkg::OP_PGRD) | (cOpQ == snf_pkg::OP_PGEX)
                             | (cOpQ == snf_pkg::OP_BERS);
  wire logic        isLoad   = (cOpQ == snf_pkg::OP_PLD) | (cOpQ == snf_pkg::OP_PLDR);
  wire logic        isRdc    = (cOpQ == snf_pkg::OP_RC1) | (cOpQ == snf_pkg::OP_RC1F)
                             | (cOpQ == snf_pkg::OP_RC2) | (cOpQ == snf_pkg::OP_RC4);
  wire logic        isSet    = cOpQ == snf_pkg::OP_SETF;
  wire logic [1:0]  need     = isRow ? snf_pkg::ROW_BYTES
                             : (isLoad | isRdc) ? snf_pkg::COL_BYTES
                             : isSet ? snf_pkg::FEAT_BYTES : 2'h0;
  wire logic        inAddr   = cCntQ < need;
  wire logic [15:0] addrN    = {cAddrQ[7:0], rxByteQ};
  wire logic        hdrDone  = rxEvt & ~rxFirstQ & inAddr & (cCntQ + 2'h1 == need);
  wire logic        dataByte = rxEvt & ~rxFirstQ & ~inAddr & (cCntQ == need);
  wire logic        simple   = rxEvt & rxFirstQ & ((rxByteQ == snf_pkg::OP_WREN)
                             | (rxByteQ == snf_pkg::OP_WRDI) | (rxByteQ == snf_pkg::OP_RST));
  wire logic        setWrite = dataByte & isSet;
  wire logic        toLock   = setWrite & (cAddrQ[7:0] == snf_pkg::FA_LOCK);
  wire logic        toOtp    = setWrite & (cAddrQ[7:0] == snf_pkg::FA_OTP);
  wire logic        lockDeny = lockQ[snf_pkg::LOCK_WD_BIT] & ~wpSyncQ[1];
  wire logic        wrInPage = wrColQ < snf_pkg::PAGE_BYTES;
  wire logic        planeN   = isRow ? addrN[snf_pkg::PLANE_ROW_BIT]
                             : addrN[snf_pkg::PLANE_COL_BIT];

  // Decoder sequencing.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cOpQ   <= 8'h00;
      cCntQ  <= 2'h0;
      cAddrQ <= 16'h0000;
    end else if (rxEvt) begin
      cOpQ   <= rxFirstQ ? rxByteQ : cOpQ;
      cCntQ  <= rxFirstQ ? 2'h0 : (inAddr | setWrite) ? cCntQ + 2'h1 : cCntQ;
      cAddrQ <= rxFirstQ ? 16'h0000 : inAddr ? addrN : cAddrQ;
    end
  end

  // Core requests; pause never reaches here, so running core work is untouched.
  // Page and block ops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdValidQ <= 1'b0;
      cmdOpQ    <= 8'h00;
      blockQ    <= 10'h000;
      pageQ     <= 6'h00;
      planeQ    <= 1'b0;
      cmdColQ   <= 12'h000;
      rdReqQ    <= 1'b0;
      rdColQ    <= 12'h000;
    end else begin
      cmdValidQ <= simple | (hdrDone & (isRow | isLoad));
      cmdOpQ    <= simple ? rxByteQ : hdrDone ? cOpQ : cmdOpQ;
      blockQ    <= (hdrDone & isRow) ? addrN[15:snf_pkg::PAGE_W] : blockQ;
      pageQ     <= (hdrDone & isRow) ? addrN[snf_pkg::PAGE_W-1:0] : pageQ;
      planeQ    <= hdrDone ? planeN : planeQ;
      cmdColQ   <= (hdrDone & isLoad) ? addrN[11:0] : cmdColQ;
      rdReqQ    <= (hdrDone & isRdc) | nxEvt;
      rdColQ    <= (hdrDone & isRdc) ? addrN[11:0] : nxEvt ? rdColQ + 12'h001 : rdColQ;
    end
  end

  // Write data; bytes past the page end are dropped.
  // Write bound
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrValidQ <= 1'b0;
      wrDataQ  <= 8'h00;
      wrColQ   <= 13'h0000;
      wrByteColQ <= 12'h000;
    end else begin
      wrValidQ <= dataByte & isLoad & wrInPage;
      // The column shown with a byte is its own, not the next free one.
      wrByteColQ <= (dataByte & isLoad & wrInPage) ? wrColQ[11:0] : wrByteColQ;
      wrDataQ  <= dataByte ? rxByteQ : wrDataQ;
      wrColQ   <= (hdrDone & isLoad) ? {1'b0, addrN[11:0]}
                : (dataByte & isLoad & wrInPage) ? wrColQ + 13'h0001 : wrColQ;
    end
  end

  // Feature registers, cache hold word and status copy read by the link.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lockQ    <= snf_pkg::LOCK_RST;
      otpQ     <= snf_pkg::OTP_RST;
      refusedQ <= 1'b0;
      holdQ    <= 8'h00;
      statQ    <= 8'h00;
    end else begin
      lockQ    <= (toLock & ~lockDeny) ? (rxByteQ & snf_pkg::LOCK_MASK) : lockQ;
      refusedQ <= toLock & lockDeny;
      otpQ     <= toOtp ? (rxByteQ & snf_pkg::OTP_MASK) : otpQ;
      holdQ    <= rdAck ? rdData : holdQ;
      statQ    <= statusIn;
    end
  end

  // Core-side outputs, all straight from flip-flops.
  assign cmdValid    = cmdValidQ;
  assign cmdOpcode   = cmdOpQ;
  assign cmdBlock    = blockQ;
  assign cmdPage     = pageQ;
  assign cmdPlane    = planeQ;
  assign cmdCol      = cmdColQ;
  assign wrValid     = wrValidQ;
  assign wrData      = wrDataQ;
  assign wrCol       = wrByteColQ;
  assign rdReq       = rdReqQ;
  assign rdCol       = rdColQ;
  assign lockReg     = lockQ;
  assign otpReg      = otpQ;
  assign eccEnable   = otpQ[snf_pkg::ECC_EN_BIT];
  assign lockRefused = refusedQ;

endmodule

// file: hdl/placeholder_none.sv
// Intentionally empty file list terminator holding no design.
`timescale 1ns/1ps

// file: sim/snf_checker.sv
// Port assertions of the serial NAND front end.
`timescale 1ns/1ps
module snf_checker (
  input wire logic        sys_clk,             // Core clock.
  input wire logic        rst,                 // Reset.
  input wire logic        spiClk,              // Link clock.
  input wire logic        csN,                 // Select.
  input wire logic        protectOrOutBit2I,   // Protect.
  input wire logic        pauseOrOutBit3I,     // Pause.
  input wire logic        serialInOrOutBit0Oe, // Lane 0.
  input wire logic        serialOutOrBit1Oe,   // Lane 1.
  input wire logic        protectOrOutBit2Oe,  // Lane 2.
  input wire logic        pauseOrOutBit3Oe,    // Lane 3.
  input wire logic        wrValid,             // Write byte.
  input wire logic [11:0] wrCol,               // Write column.
  input wire logic [7:0]  lockReg,             // Lock word.
  input wire logic [7:0]  otpReg,              // OTP word.
  input wire logic        lockRefused          // Refusal.
);
  // A pause is only a pause while the pin is not one of our own lanes.
  sequence pauseSeen;
    !pauseOrOutBit3I && !pauseOrOutBit3Oe;
  endsequence
  // Link side checks, taken at the edge that launches output bits.
  pause_float_a: assert property (@(negedge spiClk) disable iff (rst || csN)
    pauseSeen |=> !serialOutOrBit1Oe && !serialInOrOutBit0Oe) else $error("lane driven in pause");
  lanes_quad_a: assert property (@(negedge spiClk) disable iff (rst || csN)
    pauseOrOutBit3Oe |-> protectOrOutBit2Oe && serialInOrOutBit0Oe && serialOutOrBit1Oe)
    else $error("quad lanes split");
  lanes_dual_a: assert property (@(negedge spiClk) disable iff (rst || csN)
    serialInOrOutBit0Oe |-> serialOutOrBit1Oe) else $error("lane 0 without lane 1");
  // Core side checks.
  desel_float_a: assert property (@(posedge sys_clk) disable iff (rst)
    csN |-> !(serialInOrOutBit0Oe || serialOutOrBit1Oe || protectOrOutBit2Oe || pauseOrOutBit3Oe))
    else $error("lane driven while deselected");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((lockReg & ~snf_pkg::LOCK_MASK) | (otpReg & ~snf_pkg::OTP_MASK)) == 8'h00)
    else $error("reserved feature bit set");
  refuse_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    lockRefused |-> lockReg[7] && !$past(protectOrOutBit2I, 3)) else $error("refusal without cause");
  lock_guard_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(lockReg) |-> !$past(lockReg[7]) || $past(protectOrOutBit2I, 3))
    else $error("locked word changed");
  wr_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    wrValid |-> wrCol <= 12'h83F) else $error("write beyond page");
endmodule

// file: sim/snf_host_model.sv
// Host SPI master model for the front end link.
`timescale 1ns/1ps
module snf_host_model (
  output logic      spiClk,  // Link clock.
  output logic      csN,     // Select.
  output logic      pin0,    // Pin 0 level.
  output logic      pin2,    // Pin 2 level.
  output logic      pin3,    // Pin 3 level.
  input wire logic  o0,      // Pin 0 value.
  input wire logic  oe0,     // Pin 0 enable.
  input wire logic  o1,      // Pin 1 value.
  input wire logic  oe1,     // Pin 1 enable.
  input wire logic  o2,      // Pin 2 value.
  input wire logic  oe2,     // Pin 2 enable.
  input wire logic  o3,      // Pin 3 value.
  input wire logic  oe3,     // Pin 3 enable.
  input wire logic  protLvl, // Protect level.
  input wire logic  mode3    // Idle high clock.
);
  logic hOe0, hOe23, hD0, pause, pin1, l0, l1, l2, l3;
  // Released pins flip every edge so a stale level can never pass as data.
  assign pin0 = oe0 ? o0 : (hOe0 ? hD0 : ~l0);
  assign pin1 = oe1 ? o1 : ~l1;
  assign pin2 = oe2 ? o2 : (hOe23 ? protLvl : ~l2);
  assign pin3 = oe3 ? o3 : (hOe23 ? pause : ~l3);
  always @(spiClk) {l0, l1, l2, l3} <= {pin0, pin1, pin2, pin3};
  initial {spiClk, csN, hOe0, hOe23, hD0, pause} = 6'h1F;
  // Bits are set with the clock low and taken on its rise.
  task automatic xfer(input logic [63:0] tx, input int ntx, lanes, nrx, pauseAt,
                      output logic [15:0] rx);
    int k;
    k = 0;
    rx = 16'h0000;
    spiClk = mode3;
    #15 csN = 1'b0;
    for (int c = 0; k < ntx * 8 + nrx * 8 / lanes; c++) begin
      spiClk = 1'b0;
      // Pins move a little after the falling edge, so no edge sees them change.
      #2;
      // Shared pins let go once read data is due.
      hOe0 = k < ntx * 8 || lanes == 1;
      hOe23 = k < ntx * 8 || lanes != 4;
      hD0 = tx[63 - k % 64];
      // Pause moves only while the clock is low.
      pause = c < pauseAt || c > pauseAt + 1;
      #13;
      if (k >= ntx * 8)
        rx = lanes == 4 ? {rx[11:0], pin3, pin2, pin1, pin0} :
             lanes == 2 ? {rx[13:0], pin1, pin0} : {rx[14:0], pin1};
      spiClk = 1'b1;
      k += pause;
      #15;
    end
    spiClk = mode3;
    #15 {csN, hOe0, hOe23, pause} = 4'hF;
    #120;
  endtask
endmodule

// file: sim/snf_front_end_tb.sv
// Self-checking bench of the serial NAND front end.
`timescale 1ns/1ps
module snf_front_end_tb;
  logic             sys_clk, rst, protLvl, mode3, rdAck;
  logic [7:0]       rdData, statusIn;
  logic [15:0]      rx, wrSeen;
  int               fails = 0, comparisons = 0, cmds = 0, wrs = 0, refusals = 0, n;
  wire logic        spiClk, csN, pin0, pin2, pin3, o0, oe0, o1, oe1, o2, oe2, o3, oe3;
  wire logic        cmdValid, cmdPlane, wrValid, rdReq, eccEnable, lockRefused;
  wire logic [7:0]  cmdOpcode, lockReg, otpReg, wrData;
  wire logic [9:0]  cmdBlock;
  wire logic [5:0]  cmdPage;
  wire logic [11:0] wrCol, rdCol, cmdCol;
  snf_front_end u_snf_front_end (.sys_clk, .rst, .spiClk, .csN, .serialInOrOutBit0I(pin0),
    .serialInOrOutBit0O(o0), .serialInOrOutBit0Oe(oe0), .serialOutOrBit1O(o1),
    .serialOutOrBit1Oe(oe1), .protectOrOutBit2I(pin2), .protectOrOutBit2O(o2),
    .protectOrOutBit2Oe(oe2), .pauseOrOutBit3I(pin3), .pauseOrOutBit3O(o3),
    .pauseOrOutBit3Oe(oe3), .cmdValid, .cmdOpcode, .cmdBlock, .cmdPage, .cmdPlane, .cmdCol,
    .wrValid, .wrData, .wrCol, .rdReq, .rdCol, .rdData, .rdAck, .statusIn, .lockReg,
    .otpReg, .eccEnable, .lockRefused);
  snf_host_model u_snf_host_model (.spiClk, .csN, .pin0, .pin2, .pin3, .o0, .oe0, .o1, .oe1,
    .o2, .oe2, .o3, .oe3, .protLvl, .mode3);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Cache model answers each request one cycle on; pulses are counted alongside.
  always @(posedge sys_clk) begin
    #1 rdAck = rdReq;
    rdData = rdCol[7:0] ^ 8'h3C;
    cmds += (cmdValid === 1'b1);
    wrs += (wrValid === 1'b1);
    refusals += (lockRefused === 1'b1);
    if (wrValid === 1'b1) wrSeen = {wrSeen[7:0], wrData};
  end
  task automatic go(input logic [63:0] tx, input int ntx, lanes, nrx, pauseAt = 999);
    u_snf_host_model.xfer(tx, ntx, lanes, nrx, pauseAt, rx);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // The sequence needs some 16 us; 300 us without an end is a hang.
  initial begin
    #300000;
    fails++;
    final_report();
  end
  initial begin
    {rst, protLvl, mode3, rdAck, rdData, statusIn} = {4'hC, 16'h0096};
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge sys_clk);
    go(64'h0FA0_0000_0000_0000, 2, 1, 1);
    check("lock read", 16'h0000, rx);
    go(64'h0FC0_0000_0000_0000, 2, 1, 1);
    check("status read", 16'h0096, rx);
    go(64'h1FA0_FF00_0000_0000, 3, 1, 0);
    check("lock set", 16'h00B8, lockReg);
    mode3 = 1'b1;
    go(64'h0FA0_0000_0000_0000, 2, 1, 1);
    check("mode 3 read", 16'h00B8, rx);
    @(posedge sys_clk) #1 {mode3, protLvl} = 2'h0;
    #200 go(64'h1FA0_0000_0000_0000, 3, 1, 0);
    check("locked word", 16'h00B8, lockReg);
    check("refusals", 16'h0001, refusals);
    @(posedge sys_clk) #1 protLvl = 1'b1;
    #200 go(64'h1FA0_0000_0000_0000, 3, 1, 0);
    check("unlocked word", 16'h0000, lockReg);
    go(64'h1FB0_1000_0000_0000, 3, 1, 0, 20);
    check("ecc enable", 16'h0001, eccEnable);
    go(64'h1300_0140_0000_0000, 4, 1, 0);
    check("row", 16'h1380, {cmdOpcode, cmdPlane, 1'b0, cmdPage});
    check("block", 16'h0005, cmdBlock);
    n = cmds;
    go(64'h1300_0000_0000_0000, 2, 1, 0);
    go(64'h0600_0000_0000_0000, 1, 1, 0);
    check("command count", n + 1, cmds);
    go(64'h9F00_0000_0000_0000, 2, 1, 2);
    check("id", 16'hA55A, rx);
    // Each cache read width fetches the same two bytes.
    for (int i = 0; i < 3; i++) begin
      go({i == 0 ? 8'h03 : i == 1 ? 8'h3B : 8'h6B, 56'h1020_0000_0000_00}, 4, 1 << i, 2);
      check("cache read", 16'h1C1D, rx);
    end
    n = wrs;
    go(64'h8408_3E11_2233_0000, 6, 1, 0);
    check("write bytes", n + 2, wrs);
    check("last column", 16'h083F, wrCol);
    check("load column", 16'h083E, cmdCol);
    check("write data", 16'h1122, wrSeen);
    final_report();
  end
endmodule
bind snf_front_end snf_checker u_snf_checker (.sys_clk, .rst, .spiClk, .csN, .protectOrOutBit2I,
  .pauseOrOutBit3I, .serialInOrOutBit0Oe, .serialOutOrBit1Oe, .protectOrOutBit2Oe,
  .pauseOrOutBit3Oe, .wrValid, .wrCol, .lockReg, .otpReg, .lockRefused);
